// ==== logic/mcp_protect.sv ====
// motor current protection stages with motor status and apb registers
//
// Added by the designer: the address map and register access over APB.
`timescale 1ns/10ps
module mcp_protect import mcp_pkg::*; #(
  parameter int unsigned TICK_CYCLES = TICK_CYC  // shorten in simulation
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire mcp_meas_t   meas,
  output mcp_out_t         prot
);

  logic [31:0]      ctrl;         // group select and delay mode
  logic [31:0]      su_cur;       // start detect and rated start current
  logic [31:0]      su_time;      // supervision delays
  logic [31:0]      ns_a [4];     // start setting and mode per group
  logic [31:0]      ns_b [4];     // definite time and multiplier per group
  logic [15:0]      start_cnt;    // motor start counter
  logic [15:0]      run_cnt;      // motor run counter
  logic [31:0]      tick_div;     // tick prescaler
  logic             tick;         // one-cycle 1 ms strobe
  mcp_state_t       state;        // motor status
  logic [TMR_W-1:0] stop_ms;      // time spent stopped
  logic [TMR_W-1:0] rise_ms;      // time since leaving stop
  logic [TMR_W-1:0] run_ms;       // time spent running
  logic [TMR_W-1:0] ns_ms;        // negative-sequence operate timer
  logic [TMR_W-1:0] po_ms;        // phase order operate timer
  logic [TMR_W-1:0] su_ms;        // supervision operate timer
  logic             wr_en;        // completed write
  logic             setup;        // apb setup cycle
  logic             mapped;       // address decodes
  logic [31:0]      rd_word;      // read mux
  logic [1:0]       grp;          // active setting group
  logic [17:0]      sum3;         // sum of phase currents
  logic [15:0]      imax;         // largest phase current
  logic             st_go;        // enter starting
  logic             rn_go;        // enter running

  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pready & pwrite;
  assign grp   = ctrl[1:0];

  // phase sum and maximum; the average is compared as 3x threshold
  // so no divider is needed
  always_comb begin
    sum3 = 18'(meas.l1) + 18'(meas.l2) + 18'(meas.l3);
    imax = meas.l1;
    if (meas.l2 > imax) begin
      imax = meas.l2;
    end
    if (meas.l3 > imax) begin
      imax = meas.l3;
    end
  end

  // address decode and read mux
  always_comb begin
    mapped  = 1'b1;
    rd_word = 32'h00000000;
    if (paddr >= OFS_NS_BASE && paddr[1:0] == 2'h0) begin
      rd_word = paddr[2] ? ns_b[paddr[4:3]] : ns_a[paddr[4:3]];
      mapped  = (paddr[7:5] == OFS_NS_BASE[7:5]);
    end else begin
      unique case (paddr)
        OFS_CTRL:    rd_word = ctrl;
        OFS_SU_CUR:  rd_word = su_cur;
        OFS_SU_TIME: rd_word = su_time;
        OFS_STATUS:  rd_word = {23'h000000, prot};
        OFS_COUNT:   rd_word = {run_cnt, start_cnt};
        default:     mapped  = 1'b0;
      endcase
    end
  end

  // apb answer: one wait-free access phase, data set up in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~mapped;
      prdata  <= (setup & ~pwrite & mapped) ? rd_word : 32'h00000000;
    end
  end

  // software settings; clear bits of ctrl are command pulses, not stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl    <= CTRL_RST;
      su_cur  <= SU_CUR_RST;
      su_time <= SU_TIME_RST;
      for (int g = 0; g < 4; g++) begin
        ns_a[g] <= NS_A_RST;
        ns_b[g] <= NS_B_RST;
      end
    end else if (wr_en && !pslverr) begin
      if (paddr == OFS_CTRL) begin
        ctrl <= pwdata & CTRL_MASK;
      end
      if (paddr == OFS_SU_CUR) begin
        su_cur <= pwdata;
      end
      if (paddr == OFS_SU_TIME) begin
        su_time <= pwdata & SU_TIME_MSK;
      end
      if (paddr[7:5] == OFS_NS_BASE[7:5]) begin
        if (paddr[2]) begin
          ns_b[paddr[4:3]] <= pwdata & NS_B_MASK;
        end else begin
          ns_a[paddr[4:3]] <= pwdata & NS_A_MASK;
        end
      end
    end
  end

  // fixed 1 ms tick from pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_div <= 32'h00000000;
      tick     <= 1'b0;
    end else begin
      tick     <= (tick_div == TICK_CYCLES - 1);
      tick_div <= (tick_div == TICK_CYCLES - 1) ? 32'h00000000 : tick_div + 32'h00000001;
    end
  end

  // motor status transitions, judged on each tick
  always_comb begin
    st_go = (sum3 > 18'(su_cur[15:0]) * 18'h3)
          && rise_ms <= RISE_MAX_MS && stop_ms >= STOP_MIN_MS;
    // soft start: a rise too slow to count as a start lands in running
    rn_go = (state == MCP_STOPPED && !st_go && rise_ms > RISE_MAX_MS
             && sum3 >= 18'(RUN_LO) * 18'h3)
         || (state == MCP_STARTING && sum3 >= 18'(RUN_LO) * 18'h3
             && sum3 <= 18'(RUN_HI) * 18'h3);
  end

  // motor status machine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= MCP_STOPPED;
    end else if (tick) begin
      if (sum3 < 18'(STOP_LIM) * 18'h3) begin
        state <= MCP_STOPPED;
      end else if (state == MCP_STOPPED && st_go) begin
        state <= MCP_STARTING;
      end else if (rn_go) begin
        state <= MCP_RUNNING;
      end
      // otherwise starting holds until running terms are met
    end
  end

  // stop and rise timers feeding the status machine, run timer feeding the phase order stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_ms <= '0;
      rise_ms <= '0;
      run_ms  <= '0;
    end else if (tick) begin
      if (sum3 < 18'(STOP_LIM) * 18'h3) begin
        stop_ms <= (stop_ms == '1) ? stop_ms : stop_ms + 1'b1;
        rise_ms <= '0;
      end else begin
        rise_ms <= (rise_ms == '1) ? rise_ms : rise_ms + 1'b1;
      end
      // a stop only counts again once the motor has stopped anew
      if (state != MCP_STOPPED) begin
        stop_ms <= '0;
      end
      if (state == MCP_RUNNING) begin
        run_ms <= (run_ms == '1) ? run_ms : run_ms + 1'b1;
      end else begin
        run_ms <= '0;
      end
    end
  end

  // start and run counters; a clear and an increment in the same cycle leave the counter at 1
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_cnt <= 16'h0000;
      run_cnt   <= 16'h0000;
    end else begin
      if (tick && state == MCP_STOPPED && st_go && sum3 >= 18'(STOP_LIM) * 18'h3) begin
        start_cnt <= (wr_en && paddr == OFS_CTRL && pwdata[CTRL_CLR_ST])
                     ? 16'h0001 : start_cnt + 16'h0001;
      end else if (wr_en && paddr == OFS_CTRL && pwdata[CTRL_CLR_ST]) begin
        start_cnt <= 16'h0000;
      end
      if (tick && state != MCP_RUNNING && rn_go && sum3 >= 18'(STOP_LIM) * 18'h3) begin
        run_cnt <= (wr_en && paddr == OFS_CTRL && pwdata[CTRL_CLR_RN])
                   ? 16'h0001 : run_cnt + 16'h0001;
      end else if (wr_en && paddr == OFS_CTRL && pwdata[CTRL_CLR_RN]) begin
        run_cnt <= 16'h0000;
      end
    end
  end

  // negative-sequence stage
  logic        ns_pick;   // pickup condition
  logic        ns_due;    // delay expired
  logic [31:0] ns_diff;   // x^2 - k2^2, scaled by 1e6
  always_comb begin
    ns_pick = meas.neg > ns_a[grp][15:0]
              && meas.sec1 > SEC_MIN_MA && meas.sec2 > SEC_MIN_MA
              && meas.sec3 > SEC_MIN_MA;
    ns_diff = 32'(meas.neg) * 32'(meas.neg)
            - 32'(ns_a[grp][15:0]) * 32'(ns_a[grp][15:0]);
    if (ns_a[grp][16]) begin
      // elapsed * diff >= k1 * 1e9 avoids a divider
      ns_due = 64'(ns_ms) * 64'(ns_diff)
               >= 64'(ns_b[grp][21:16]) * 64'(MS_PER_S) * 64'h3e8
            || ns_ms >= NS_MAX_MS;
    end else begin
      ns_due = 40'(ns_ms) >= 40'(ns_b[grp][12:0]) * 40'(DS_MS);
    end
  end

  // phase order stage, one fixed group
  logic po_pick;
  always_comb begin
    po_pick = 24'(meas.neg) * 24'(PCT_FULL) > 24'(meas.pos) * 24'(PO_RATIO)
              && sum3 > 18'(PO_MIN) * 18'h3
              && (meas.l1 > PO_MIN || meas.l2 > PO_MIN || meas.l3 > PO_MIN)
              && (state == MCP_STARTING
                  || (state == MCP_RUNNING && run_ms < PO_BLK_MS));
  end

  // start-up supervision, active only in the starting state
  logic su_pick;
  logic su_due;
  always_comb begin
    su_pick = (state == MCP_STARTING) && (sum3 >= 18'(RUN_HI) * 18'h3);
    if (ctrl[2]) begin
      // elapsed * imeas^2 >= max_allowed_start_time * ist^2
      su_due = 64'(su_ms) * 64'(32'(imax) * 32'(imax))
               >= 64'(su_time[27:16]) * 64'(DS_MS)
                  * 64'(32'(su_cur[31:16]) * 32'(su_cur[31:16]));
    end else begin
      su_due = 32'(su_ms) >= 32'(su_time[11:0]) * 32'(DS_MS);
    end
  end

  // operate timers; each clears as soon as its stage drops out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ns_ms <= '0;
      po_ms <= '0;
      su_ms <= '0;
    end else begin
      if (!ns_pick) begin
        ns_ms <= '0;
      end else if (tick && ns_ms != '1) begin
        ns_ms <= ns_ms + 1'b1;
      end
      if (!po_pick) begin
        po_ms <= '0;
      end else if (tick && po_ms != '1) begin
        po_ms <= po_ms + 1'b1;
      end
      if (!su_pick) begin
        su_ms <= '0;
      end else if (tick && su_ms != '1) begin
        su_ms <= su_ms + 1'b1;
      end
    end
  end

  // registered outputs to the output and block matrix
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prot <= '0;
    end else begin
      prot.ns_start <= ns_pick;
      prot.ns_trip  <= ns_pick && ns_due;
      prot.po_start <= po_pick;
      prot.po_trip  <= po_pick && po_ms >= PO_TRIP_MS;
      prot.su_start <= su_pick;
      prot.su_trip  <= su_pick && su_due;
      prot.stopped  <= (state == MCP_STOPPED);
      prot.starting <= (state == MCP_STARTING);
      prot.running  <= (state == MCP_RUNNING);
    end
  end

endmodule : mcp_protect

// ==== pkg/mcp_pkg.sv ====
// constants, types and register map of the motor current protection block
package mcp_pkg;
  // currents are in milli per-unit of rated motor current, secondary currents in mA
  localparam int unsigned CLK_NS      = 25;
  localparam int unsigned TICK_NS     = 1000000;           // one timer tick is 1 ms
  localparam int unsigned TICK_CYC    = TICK_NS / CLK_NS;  // pclk cycles per tick
  localparam int unsigned TMR_W       = 20;
  localparam logic [15:0] STOP_LIM    = 16'h0064;          // 0.10 pu
  localparam logic [15:0] RUN_LO      = 16'h00c8;          // 0.20 pu
  localparam logic [15:0] RUN_HI      = 16'h04b0;          // 1.20 pu
  localparam logic [15:0] PO_MIN      = 16'h00c8;          // 0.20 pu
  localparam logic [15:0] SEC_MIN_MA  = 16'h00fa;          // 250 mA
  localparam logic [7:0]  PO_RATIO    = 8'h50;             // 80 percent, fixed
  localparam logic [7:0]  PCT_FULL    = 8'h64;             // 100 percent
  localparam logic [19:0] STOP_MIN_MS = 20'h001f4;         // 500 ms
  localparam logic [19:0] RISE_MAX_MS = 20'h000c8;         // 200 ms
  localparam logic [19:0] PO_TRIP_MS  = 20'h00064;         // 100 ms
  localparam logic [19:0] PO_BLK_MS   = 20'h007d0;         // 2 s
  localparam logic [19:0] NS_MAX_MS   = 20'hf4240;         // 1000 s
  localparam logic [19:0] DS_MS       = 20'h00064;         // 0.1 s setting step
  localparam logic [31:0] MS_PER_S    = 32'h000f4240;      // 1000 ms times 1000 scale
  // register byte offsets
  localparam logic [7:0]  OFS_CTRL    = 8'h00;
  localparam logic [7:0]  OFS_SU_CUR  = 8'h04;
  localparam logic [7:0]  OFS_SU_TIME = 8'h08;
  localparam logic [7:0]  OFS_STATUS  = 8'h0c;
  localparam logic [7:0]  OFS_COUNT   = 8'h10;
  localparam logic [7:0]  OFS_NS_BASE = 8'h20;             // 8 bytes per group
  // field positions
  localparam int unsigned CTRL_CLR_ST = 3;
  localparam int unsigned CTRL_CLR_RN = 4;
  // masks and reset values
  localparam logic [31:0] CTRL_MASK   = 32'h00000007;
  localparam logic [31:0] SU_TIME_MSK = 32'h0fff0fff;
  localparam logic [31:0] NS_A_MASK   = 32'h0001ffff;
  localparam logic [31:0] NS_B_MASK   = 32'h003f1fff;
  localparam logic [31:0] CTRL_RST    = 32'h00000000;
  localparam logic [31:0] SU_CUR_RST  = 32'h177007d0;      // rated 6.00, detect 2.00
  localparam logic [31:0] SU_TIME_RST = 32'h00640064;      // 10.0 s both
  localparam logic [31:0] NS_A_RST    = 32'h00000032;      // 0.05 pu, definite
  localparam logic [31:0] NS_B_RST    = 32'h0001000a;      // 1.0 s, multiplier 1 s

  typedef enum logic [1:0] {MCP_STOPPED, MCP_STARTING, MCP_RUNNING} mcp_state_t;

  // measured fundamental values from the measurement side
  typedef struct packed {
    logic [15:0] l1;       // phase currents, milli pu
    logic [15:0] l2;
    logic [15:0] l3;
    logic [15:0] neg;      // negative sequence, milli pu
    logic [15:0] pos;      // positive sequence, milli pu
    logic [15:0] sec1;     // secondary phase currents, mA
    logic [15:0] sec2;
    logic [15:0] sec3;
  } mcp_meas_t;

  // start, trip and status bits toward the output and block matrix
  typedef struct packed {
    logic ns_start;
    logic ns_trip;
    logic po_start;
    logic po_trip;
    logic su_start;
    logic su_trip;
    logic stopped;
    logic starting;
    logic running;
  } mcp_out_t;
endpackage : mcp_pkg

// ==== verification/mcp_meas_src.sv ====
// measurement side model feeding fundamental and sequence currents
`timescale 1ns/10ps
module mcp_meas_src import mcp_pkg::*; (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [15:0] cur,      // all phases, milli pu
  input  wire logic [15:0] neg,      // negative sequence, milli pu
  input  wire logic [15:0] pos,      // positive sequence, milli pu
  input  wire logic [15:0] sec,      // secondary current, mA
  output mcp_meas_t        meas
);
  // registered like a filter output; balanced phases keep max equal to average
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meas <= '0;
    end else begin
      meas <= '{cur, cur, cur, neg, pos, sec, sec, sec};
    end
  end
endmodule : mcp_meas_src

// ==== verification/mcp_protect_asserts.sv ====
// concurrent checks on the protection block ports
`timescale 1ns/10ps
module mcp_protect_asserts import mcp_pkg::*; (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire mcp_meas_t   meas,
  input wire mcp_out_t    prot
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic sec_ok;  // every secondary above the minimum
  logic po_ok;   // at least one phase above the minimum
  logic was_idle; // stopped or starting, the only states running may follow
  assign was_idle = prot.stopped || prot.starting;
  assign sec_ok = meas.sec1 > SEC_MIN_MA && meas.sec2 > SEC_MIN_MA && meas.sec3 > SEC_MIN_MA;
  assign po_ok  = meas.l1 > PO_MIN || meas.l2 > PO_MIN || meas.l3 > PO_MIN;

  AST_APB_READY: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready held too long");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_STATE_ONEHOT: assert property ($onehot0({prot.stopped, prot.starting, prot.running}))
    else $error("motor status not one hot");
  AST_START_FROM_STOP: assert property ($rose(prot.starting) |-> $past(prot.stopped))
    else $error("starting entered not from stopped");
  AST_RUN_ENTRY: assert property ($rose(prot.running) |-> $past(was_idle))
    else $error("running entered from bad state");
  AST_SU_IN_START: assert property (prot.su_start |-> prot.starting || $past(prot.starting))
    else $error("supervision active outside starting");
  AST_NS_SEC_MIN: assert property (prot.ns_start |-> $past(sec_ok) || $past(sec_ok, 2))
    else $error("neg seq start with low secondary");
  AST_PO_CUR_MIN: assert property (prot.po_start |-> $past(po_ok) || $past(po_ok, 2))
    else $error("phase order start with low current");
  AST_PO_TRIP_DELAY: assert property ($rose(prot.po_start) |-> !prot.po_trip [*8])
    else $error("phase order trip too early");
  AST_SU_TRIP_START: assert property ($rose(prot.su_trip) |-> $past(prot.su_start))
    else $error("supervision trip without start");
  AST_NS_TRIP_START: assert property ($rose(prot.ns_trip) |-> $past(prot.ns_start))
    else $error("neg seq trip without start");
  cover property ($rose(prot.starting));
  cover property ($rose(prot.su_trip));
  cover property ($rose(prot.ns_trip));
endmodule : mcp_protect_asserts

// ==== verification/tb.sv ====
// self-checking testbench of the motor current protection block
`timescale 1ns/10ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
  $display("mismatch t=%0t got=%0h exp=%0h", $time, g, e); end end
module tb import mcp_pkg::*; ();
  localparam int T = 4;  // cycles per tick, keeps long delays short
  localparam int RN = 0, ST = 1, SUT = 3, SUS = 4, POT = 5, POS = 6, NST = 7, NSS = 8;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] cur, neg, pos, sec;
  mcp_meas_t   meas;
  mcp_out_t    prot;
  int          err_total, samples_checked, n;

  mcp_protect #(.TICK_CYCLES(T)) u_mcp_protect (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .meas(meas), .prot(prot));
  mcp_meas_src u_mcp_meas_src (.pclk(pclk), .presetn(presetn), .cur(cur), .neg(neg),
    .pos(pos), .sec(sec), .meas(meas));

  // free running bus clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // one apb transfer, held until ready is sampled
  // no local limit: only the watchdog may end a wait for ready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // bounded wait for an output bit, n holds the cycles spent
  task wt(input int b, input int lim);
    n = 0;
    while (prot[b] !== 1'b1 && n < lim) begin @(posedge pclk); n++; end
    `CHK(prot[b], 1'b1)
  endtask : wt
  task ms(input int m); repeat (m * T) @(posedge pclk); endtask : ms
  // motor at standstill long enough, then a new current level
  task stop_then(input logic [15:0] c);
    cur <= '0; neg <= '0; ms(600);
    cur <= c;
  endtask : stop_then

  task sc_regs;
    static logic [7:0]  ad [5] = '{OFS_CTRL, OFS_SU_CUR, OFS_SU_TIME, 8'h20, 8'h3c};
    static logic [31:0] rv [5] = '{CTRL_RST, SU_CUR_RST, SU_TIME_RST, NS_A_RST, NS_B_RST};
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, ad[i], '0); `CHK(rd, rv[i])
    end
    apb(1'b1, 8'h30, 32'hffffffff); apb(1'b0, 8'h30, '0); `CHK(rd, NS_A_MASK)
    apb(1'b0, 8'h20, '0); `CHK(rd, NS_A_RST)
    apb(1'b1, 8'h30, NS_A_RST); apb(1'b0, 8'h1c, '0); `CHK({err, rd}, 33'h100000000)
    $display("done sc_regs");
  endtask : sc_regs

  task sc_dol;
    stop_then(16'h09c4); `CHK(prot.stopped, 1'b1)
    neg <= 16'h0384; pos <= 16'h03e8; sec <= 16'h03e8;  // ratio 90 percent
    wt(ST, 210 * T);
    wt(SUS, 4);
    wt(POS, 8);
    wt(POT, 110 * T); `CHK(n >= 98 * T, 1'b1)
    apb(1'b0, OFS_COUNT, '0); `CHK(rd[15:0], 16'h0001)
    cur <= 16'h03e8; neg <= '0; wt(RN, 20 * T); `CHK(prot.su_start, 1'b0)
    apb(1'b0, OFS_COUNT, '0); `CHK(rd[31:16], 16'h0001)
    ms(2100); neg <= 16'h0384; ms(5); `CHK(prot.po_start, 1'b0)
    wt(NSS, 8);
    wt(NST, 1100 * T); `CHK(n >= 990 * T, 1'b1)
    sec <= 16'h00c8; ms(2); `CHK(prot[NSS:NST], 2'b00)
    apb(1'b1, 8'h20, 32'h00010032); neg <= 16'h03e8; sec <= 16'h03e8;
    wt(NSS, 8);
    wt(NST, 1100 * T); `CHK(n >= 995 * T && n <= 1010 * T, 1'b1)
    // group 1 gets a 2.00 pu start level, so selecting it drops the start
    apb(1'b1, 8'h28, 32'h000007d0); apb(1'b1, OFS_CTRL, 32'h00000001);
    ms(1); `CHK(prot.ns_start, 1'b0)
    neg <= '0; apb(1'b1, OFS_CTRL, 32'h00000018); apb(1'b0, OFS_COUNT, '0); `CHK(rd, '0)
    $display("done sc_dol");
  endtask : sc_dol

  task sc_soft;
    stop_then(16'h01f4); wt(RN, 300 * T);
    apb(1'b0, OFS_COUNT, '0); `CHK(rd, 32'h00010000)
    apb(1'b0, OFS_STATUS, '0); `CHK(rd, 32'h00000001)
    $display("done sc_soft");
  endtask : sc_soft

  task sc_su;
    apb(1'b1, OFS_SU_TIME, 32'h0064000a); stop_then(16'h09c4);
    neg <= 16'h0320;  // ratio exactly 80 percent, must not start phase order
    wt(SUS, 220 * T);
    `CHK(prot.po_start, 1'b0)
    wt(SUT, 1100 * T); `CHK(n >= 990 * T, 1'b1)
    cur <= 16'h03e8; wt(RN, 20 * T); `CHK(prot.su_trip, 1'b0)
    apb(1'b1, OFS_CTRL, 32'h00000004); apb(1'b1, OFS_SU_TIME, 32'h0005000a);
    stop_then(16'h0bb8); wt(SUS, 220 * T);
    wt(SUT, 2100 * T); `CHK(n >= 1980 * T && n <= 2020 * T, 1'b1)
    $display("done sc_su");
  endtask : sc_su

  task report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  // watchdog, well beyond the expected run length
  initial begin
    repeat (100000) @(posedge pclk);
    err_total++;
    report_and_stop;
  end
  // reset, then the scenarios in order
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    cur = '0; neg = '0; pos = '0; sec = '0; err_total = 0; samples_checked = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    sc_regs;
    sc_dol;
    sc_soft;
    sc_su;
    report_and_stop;
  end
endmodule : tb

bind mcp_protect mcp_protect_asserts u_mcp_protect_asserts (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .prdata(prdata), .pslverr(pslverr), .meas(meas), .prot(prot));
